// File: hw/bst_regs.svh
// register map, field positions and timing counts of the backoff self-test block
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
`define BST_OFF_CTRL 12'h000
`define BST_OFF_BASE 12'h004
`define BST_OFF_CMD 12'h008
`define BST_OFF_LINK 12'h00C
`define BST_OFF_NEXT 12'h010
`define BST_OFF_STAT 12'h014
`define BST_CTRL_GO 0
`define BST_CTRL_SUSP_EVT 1
`define BST_STAT_IDLE 0
`define BST_STAT_DONE 1
`define BST_STAT_PASS 4
`define BST_CMD_LAST 31
`define BST_CMD_SUSP 30
`define BST_CMD_IREQ 29
`define BST_CMD_OP_HI 18
`define BST_CMD_OP_LO 16
`define BST_CMD_C 15
`define BST_CMD_OK 13
`define BST_CMD_F 11
`define BST_OP_DIAG 3'h7
`define BST_SLOT_STOP 12'h7FF
`define BST_SLOT_END 12'h800
`define BST_P2_SLOT 4'h3
`define BST_P2_LIN 4'h6
`define BST_P2_EXP 4'h3
`define BST_P2_MET 4'h0
`define BST_P2_LIMIT 8'h40
`endif

// File: hw/bst_pkg.sv
// types of the backoff self-test block
`default_nettype none
package bst_pkg;
    typedef enum logic [2:0] {
        BST_CU_IDLE = 3'h0,
        BST_CU_EXEC = 3'h1,
        BST_CU_WAIT = 3'h3,
        BST_CU_DONE = 3'h2,
        BST_CU_ACTIVE = 3'h6,
        BST_CU_SUSP = 3'h7
    } bst_cu_t;
    typedef enum logic [2:0] {
        BST_T_OFF = 3'h0,
        BST_T_P1_RUN = 3'h1,
        BST_T_P1_CHK = 3'h3,
        BST_T_P2_RUN = 3'h2,
        BST_T_END = 3'h6
    } bst_test_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } bst_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bst_apb_rsp_t;
    typedef struct packed {
        bst_apb_rsp_t rsp;
        bst_cu_t cu;
        bst_test_t t;
        logic susp_evt_en;
        logic [31:0] base;
        logic [31:0] blk_cmd;
        logic [31:0] blk_link;
        logic [31:0] next_addr;
        logic [1:0] sticky;
        logic idle_event;
        logic done_event;
        logic [29:0] lfsr;
        logic [9:0] tmo;
        logic [11:0] slot;
        logic [3:0] coll;
        logic [9:0] bsr;
        logic chk_err;
        logic pass;
        logic [3:0] cfg_slot;
        logic [3:0] cfg_lin;
        logic [3:0] cfg_exp;
        logic [3:0] cfg_met;
        logic [3:0] wait_cnt;
        logic [7:0] iter;
    } bst_state_t;
endpackage : bst_pkg
`default_nettype wire

// File: hw/bst_top.sv
// command unit diagnose handling and two-phase backoff self-test engine
//
// The register addresses and the APB register port were left to the implementer.
`include "bst_regs.svh"
`default_nettype none
// Operation
// - command field is bits 18:16; value 111 selects the self-test
// - last-block flag: go idle after the block, always raise idle event
// - suspend flag: go suspended, idle event only when enabled
// - interrupt-request flag raises block-done event; clear flag raises none
// - software clears completion; device sets it when finished
// - success flag set on error-free run; clear with completion means error
// - fail flag is 0 on pass, 1 on failure
// - pass gives C=1 OK=1 F=0; failure gives C=1 OK=0 F=1
// - next block address is base plus 32-bit link
// - start serial self-test, wait for its end before status
// - test runs phase one on counters, phase two on trigger logic
// - phase one starts with all counters and shifters reset together
// - shifter must be all ones when LFSR low 10 bits are ones
// - phase one stops as the 10-bit timeout counter wraps
// - at stop slot counter rolls to 800h, collision counter wraps
// - phase one passes only if low 10 bits of all counters are zero
// - phase two resets all and loads slot 3, lin 6, exp 3, method 0
// - phase two repeats emulated collisions while shifter MSB is 0
// - phase two returns pass when shifter MSB is set, else fail
module bst_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire bst_pkg::bst_apb_req_t apb_req,
    output var bst_pkg::bst_apb_rsp_t apb_rsp,
    // unit events and state
    output logic unit_idle_event,
    output logic block_done_event,
    output logic [2:0] cu_state
);
    import bst_pkg::*;

    bst_state_t st;
    bst_state_t next_st;
    logic acc;
    logic wr;
    logic diag;
    logic can_load;

    assign apb_rsp = st.rsp;
    assign unit_idle_event = st.idle_event;
    assign block_done_event = st.done_event;
    assign cu_state = st.cu;
    // one wait state: read data is latched on the same edge that raises pready so it comes from a flop
    assign acc = apb_req.psel && apb_req.penable;
    assign wr = acc && st.rsp.pready && apb_req.pwrite;
    assign diag = st.blk_cmd[`BST_CMD_OP_HI:`BST_CMD_OP_LO] == `BST_OP_DIAG;
    assign can_load = st.cu == BST_CU_IDLE || st.cu == BST_CU_ACTIVE || st.cu == BST_CU_SUSP;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] rd;
        logic bad;
        logic go;
        logic [3:0] tgt;
        rd = 32'h0;
        bad = 1'b0;
        go = 1'b0;
        tgt = 4'h0;
        next_st = st;
        next_st.idle_event = 1'b0;
        next_st.done_event = 1'b0;

        // bus: answer one cycle into the access phase
        next_st.rsp.pready = acc && !st.rsp.pready;
        case (apb_req.paddr)
            `BST_OFF_CTRL: begin
                rd = {30'h0, st.susp_evt_en, 1'b0};
            end
            `BST_OFF_BASE: begin
                rd = st.base;
            end
            `BST_OFF_CMD: begin
                rd = st.blk_cmd;
            end
            `BST_OFF_LINK: begin
                rd = st.blk_link;
            end
            `BST_OFF_NEXT: begin
                rd = st.next_addr;
            end
            `BST_OFF_STAT: begin
                rd = {21'h0, st.cu, 3'h0, st.pass, 2'h0, st.sticky};
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        if (acc && !st.rsp.pready) begin
            next_st.rsp.prdata = apb_req.pwrite ? 32'h0 : rd;
            next_st.rsp.pslverr = bad;
        end
        if (wr) begin
            case (apb_req.paddr)
                `BST_OFF_CTRL: begin
                    next_st.susp_evt_en = apb_req.pwdata[`BST_CTRL_SUSP_EVT];
                    go = apb_req.pwdata[`BST_CTRL_GO] && can_load;
                end
                `BST_OFF_BASE: begin
                    next_st.base = apb_req.pwdata;
                end
                `BST_OFF_CMD: begin
                    // block words are frozen while the unit works on them
                    if (can_load) begin
                        next_st.blk_cmd = apb_req.pwdata;
                    end
                end
                `BST_OFF_LINK: begin
                    if (can_load) begin
                        next_st.blk_link = apb_req.pwdata;
                    end
                end
                `BST_OFF_STAT: begin
                    next_st.sticky = st.sticky & ~apb_req.pwdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // command unit
        case (st.cu)
            BST_CU_IDLE, BST_CU_ACTIVE, BST_CU_SUSP: begin
                if (go) begin
                    next_st.cu = BST_CU_EXEC;
                end
            end
            BST_CU_EXEC: begin
                if (diag) begin
                    next_st.cu = BST_CU_WAIT;
                    next_st.t = BST_T_P1_RUN;
                    next_st.lfsr = 30'h0;
                    next_st.tmo = 10'h0;
                    next_st.slot = 12'h0;
                    next_st.coll = 4'h0;
                    next_st.bsr = 10'h0;
                    next_st.chk_err = 1'b0;
                    next_st.pass = 1'b0;
                end else begin
                    // other action commands are not handled: completed with error
                    next_st.cu = BST_CU_DONE;
                    next_st.blk_cmd[`BST_CMD_C] = 1'b1;
                    next_st.blk_cmd[`BST_CMD_OK] = 1'b0;
                    next_st.next_addr = st.base + st.blk_link;
                end
            end
            BST_CU_WAIT: begin
                if (st.t == BST_T_END) begin
                    next_st.cu = BST_CU_DONE;
                    next_st.t = BST_T_OFF;
                    next_st.blk_cmd[`BST_CMD_C] = 1'b1;
                    next_st.blk_cmd[`BST_CMD_OK] = st.pass;
                    next_st.blk_cmd[`BST_CMD_F] = !st.pass;
                    next_st.next_addr = st.base + st.blk_link;
                end
            end
            BST_CU_DONE: begin
                next_st.done_event = st.blk_cmd[`BST_CMD_IREQ];
                if (st.blk_cmd[`BST_CMD_LAST]) begin
                    next_st.cu = BST_CU_IDLE;
                    next_st.idle_event = 1'b1;
                end else if (st.blk_cmd[`BST_CMD_SUSP]) begin
                    next_st.cu = BST_CU_SUSP;
                    next_st.idle_event = st.susp_evt_en;
                end else begin
                    next_st.cu = BST_CU_ACTIVE;
                end
            end
            default: begin
                next_st.cu = BST_CU_IDLE;
            end
        endcase
        // set wins over a same-cycle clear
        if (next_st.idle_event) begin
            next_st.sticky[`BST_STAT_IDLE] = 1'b1;
        end
        if (next_st.done_event) begin
            next_st.sticky[`BST_STAT_DONE] = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // self-test engine
        case (st.t)
            BST_T_OFF: begin
            end
            BST_T_P1_RUN: begin
                next_st.lfsr = {st.lfsr[28:0], ~(st.lfsr[29] ^ st.lfsr[5] ^ st.lfsr[3] ^ st.lfsr[0])};
                next_st.tmo = st.tmo + 10'h1;
                next_st.slot = st.slot + 12'h1;
                next_st.coll = st.coll + 4'h1;
                next_st.bsr = {st.bsr[8:0], 1'b1};
                if (st.lfsr[9:0] == 10'h3FF && st.bsr != 10'h3FF) begin
                    next_st.chk_err = 1'b1;
                end
                if (st.slot == `BST_SLOT_STOP) begin
                    next_st.t = BST_T_P1_CHK;
                end
            end
            BST_T_P1_CHK: begin
                if (st.tmo == 10'h0 && st.slot[9:0] == 10'h0 && st.coll == 4'h0
                    && st.lfsr[29:0] != 30'h0 && !st.chk_err) begin
                    next_st.t = BST_T_P2_RUN;
                    next_st.lfsr = 30'h0;
                    next_st.tmo = 10'h0;
                    next_st.slot = 12'h0;
                    next_st.coll = 4'h0;
                    next_st.bsr = 10'h0;
                    next_st.wait_cnt = 4'h0;
                    next_st.iter = 8'h0;
                    next_st.cfg_slot = `BST_P2_SLOT;
                    next_st.cfg_lin = `BST_P2_LIN;
                    next_st.cfg_exp = `BST_P2_EXP;
                    next_st.cfg_met = `BST_P2_MET;
                end else begin
                    next_st.t = BST_T_END;
                    next_st.pass = 1'b0;
                end
            end
            BST_T_P2_RUN: begin
                // early collisions wait the extra linear priority slots
                tgt = (st.coll < st.cfg_exp) ? st.cfg_slot + st.cfg_lin : st.cfg_slot;
                next_st.wait_cnt = st.wait_cnt + 4'h1;
                if (st.bsr[9]) begin
                    next_st.t = BST_T_END;
                    next_st.pass = 1'b1;
                end else if (st.iter == `BST_P2_LIMIT) begin
                    next_st.t = BST_T_END;
                    next_st.pass = 1'b0;
                end else if (st.wait_cnt == tgt) begin
                    next_st.wait_cnt = 4'h0;
                    next_st.coll = st.coll + 4'h1;
                    next_st.iter = st.iter + 8'h1;
                    next_st.slot = st.slot + 12'h1;
                    next_st.lfsr = {st.lfsr[28:0], ~(st.lfsr[29] ^ st.lfsr[5] ^ st.lfsr[3] ^ st.lfsr[0])};
                    // method 0 widens the backoff mask one bit per collision
                    if (st.cfg_met == `BST_P2_MET) begin
                        next_st.bsr = {st.bsr[8:0], 1'b1};
                    end
                end
            end
            BST_T_END: begin
            end
            default: begin
                next_st.t = BST_T_OFF;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_diag_enters_test: assert property (
        (st.cu == BST_CU_EXEC && diag) |=> st.cu == BST_CU_WAIT && st.t == BST_T_P1_RUN)
        else $error("diagnose block did not start the self-test");
    a_last_goes_idle: assert property (
        (st.cu == BST_CU_DONE && st.blk_cmd[31]) |=> st.cu == BST_CU_IDLE && st.idle_event)
        else $error("last block did not end idle with event");
    a_suspend_event: assert property (
        (st.cu == BST_CU_DONE && !st.blk_cmd[31] && st.blk_cmd[30])
        |=> st.cu == BST_CU_SUSP && st.idle_event == $past(st.susp_evt_en))
        else $error("suspend transition or its event is wrong");
    a_done_event_req: assert property (
        $rose(st.cu == BST_CU_DONE) |=> st.done_event == $past(st.blk_cmd[29]))
        else $error("block done event does not follow request flag");
    a_status_pair: assert property (
        (st.cu == BST_CU_DONE && diag)
        |-> st.blk_cmd[15] && st.blk_cmd[13] == st.pass && st.blk_cmd[11] == !st.pass)
        else $error("completion status bits inconsistent");
    a_next_address: assert property (
        (st.cu == BST_CU_DONE) |-> st.next_addr == st.base + st.blk_link)
        else $error("next block address wrong");
    a_wait_for_test: assert property (
        (st.cu == BST_CU_WAIT && st.t != BST_T_END) |=> st.cu == BST_CU_WAIT && !st.blk_cmd[15] == !$past(st.blk_cmd[15]))
        else $error("unit left wait before test end");
    a_p1_reset_all: assert property (
        $rose(st.t == BST_T_P1_RUN) |-> st.lfsr == 30'h0 && st.tmo == 10'h0 && st.slot == 12'h0
        && st.coll == 4'h0 && st.bsr == 10'h0)
        else $error("phase one began with counters not reset");
    a_p1_stop_point: assert property (
        (st.t == BST_T_P1_RUN && st.slot == 12'h7FF) |=> st.t == BST_T_P1_CHK && st.slot == 12'h800
        && st.tmo == 10'h0 && st.coll == 4'h0)
        else $error("phase one stop point wrong");
    a_p2_config: assert property (
        (st.t == BST_T_P2_RUN) |-> st.cfg_slot == 4'h3 && st.cfg_lin == 4'h6 && st.cfg_exp == 4'h3
        && st.cfg_met == 4'h0)
        else $error("phase two temporary configuration wrong");
    a_p2_result: assert property (
        (st.t == BST_T_P2_RUN && st.bsr[9]) |=> st.t == BST_T_END && st.pass)
        else $error("phase two pass not reported");
    a_p2_bounded: assert property (
        (st.t == BST_T_P2_RUN) |-> st.iter <= 8'h40)
        else $error("phase two loop exceeded its bound");

endmodule : bst_top
`default_nettype wire

// File: bench/bst_host.sv
// host model driving apb register transfers into the self-test block
`default_nettype none
module bst_host (
    // clock
    input wire logic pclk,
    // apb master side
    output var bst_pkg::bst_apb_req_t apb_req,
    input wire bst_pkg::bst_apb_rsp_t apb_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import bst_pkg::*;
    initial begin
        apb_req = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one transfer; pready and the answer are taken at the rising edge that ends the access phase,
    // so the request stands unchanged until that edge and is released just after it
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic hung);
        int n;
        hung = 1'b1;
        rd = '0;
        err = 1'b0;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 16 && hung; n++) begin
            @(posedge pclk);
            if (apb_rsp.pready === 1'b1) begin
                rd = apb_rsp.prdata;
                err = apb_rsp.pslverr;
                hung = 1'b0;
            end
        end
        apb_req <= '0;
    endtask : xfer
endmodule : bst_host
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the backoff self-test block
`include "bst_regs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bst_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    bst_apb_req_t apb_req;
    bst_apb_rsp_t apb_rsp;
    logic unit_idle_event;
    logic block_done_event;
    logic [2:0] cu_state;
    int mismatches = 0;
    int num_checks = 0;
    int idle_cnt = 0;
    int done_cnt = 0;
    int k;
    bst_top bst_top_i (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .unit_idle_event(unit_idle_event),
        .block_done_event(block_done_event),
        .cu_state(cu_state)
    );
    bst_host bst_host_i (
        .pclk(pclk),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp)
    );
    initial begin
        forever #25 pclk = ~pclk;
    end
    // event pulses last one cycle, so they are counted mid-cycle
    always @(negedge pclk) begin
        if (unit_idle_event === 1'b1) idle_cnt++;
        if (block_done_event === 1'b1) done_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic hang(input logic h);
        if (h) begin
            mismatches++;
            $display("FAIL at %0t: no answer in time", $time);
            summarize();
        end
    endtask : hang
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        logic h;
        bst_host_i.xfer(1'b1, a, d, x, e, h);
        hang(h);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err, input string what);
        logic [31:0] x;
        logic e;
        logic h;
        bst_host_i.xfer(1'b0, a, 32'h0, x, e, h);
        hang(h);
        check({31'h0, e}, {31'h0, exp_err}, what);
        check(x, exp, what);
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////////////////
    // issue one block, wait for completion, then compare status, final state and events
    task automatic run_block(input logic [31:0] cmd, input logic [31:0] ctrl, input logic [31:0] exp_cmd,
                             input logic [2:0] exp_state, input int exp_idle, input int exp_done);
        int n;
        wr(`BST_OFF_CMD, cmd);
        idle_cnt = 0;
        done_cnt = 0;
        wr(`BST_OFF_CTRL, ctrl);
        // a rewrite while the test runs must be refused, or the status check below breaks
        if (cmd[18:16] == `BST_OP_DIAG) wr(`BST_OFF_CMD, 32'h0);
        for (n = 0; n < 8000 && cu_state !== 3'h2; n++) @(negedge pclk);
        hang(n >= 8000);
        repeat (3) @(negedge pclk);
        check({29'h0, cu_state}, {29'h0, exp_state}, "final state");
        check(idle_cnt, exp_idle, "idle events");
        check(done_cnt, exp_done, "done events");
        rd_chk(`BST_OFF_CMD, exp_cmd, 1'b0, "status word");
    endtask : run_block
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({29'h0, cu_state}, 32'h0, "state after reset");
        rd_chk(`BST_OFF_STAT, 32'h0, 1'b0, "stat after reset");
        rd_chk(12'h018, 32'h0, 1'b1, "unmapped read");
        // base near the top so the link sum wraps in 32 bits
        wr(`BST_OFF_BASE, 32'hFFFF_FFF0);
        wr(`BST_OFF_LINK, 32'h0000_0020);
        // command words keep reserved bits zero and completion clear
        run_block(32'hA007_0000, 32'h1, 32'hA007_A000, 3'h0, 1, 1);
        rd_chk(`BST_OFF_NEXT, 32'h0000_0010, 1'b0, "next block");
        rd_chk(`BST_OFF_STAT, 32'h0000_0013, 1'b0, "stat after pass");
        wr(`BST_OFF_STAT, 32'h3);
        rd_chk(`BST_OFF_STAT, 32'h0000_0010, 1'b0, "stat cleared");
        run_block(32'h4007_0000, 32'h1, 32'h4007_A000, 3'h7, 0, 0);
        run_block(32'h4007_0000, 32'h3, 32'h4007_A000, 3'h7, 1, 0);
        run_block(32'h0007_0000, 32'h1, 32'h0007_A000, 3'h6, 0, 0);
        // every other operation code completes at once with an error and fail untouched
        for (k = 0; k < 7; k++) begin
            run_block(32'h8000_0800 | (32'(k) << 16), 32'h1, 32'h8000_8800 | (32'(k) << 16), 3'h0, 1, 0);
        end
        // a reset in the middle of a self-test must leave the unit idle with the command and status words cleared
        wr(`BST_OFF_CMD, 32'h8007_0000);
        wr(`BST_OFF_CTRL, 32'h1);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({29'h0, cu_state}, 32'h0, "state after second reset");
        rd_chk(`BST_OFF_CMD, 32'h0, 1'b0, "cmd after second reset");
        rd_chk(`BST_OFF_STAT, 32'h0, 1'b0, "stat after second reset");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
